// ===== wgss_pkg.sv
package wgss_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFS_GEN_CTRL = 8'h00;
   localparam logic [7:0] OFS_POLARITY = 8'h04;
   localparam logic [7:0] OFS_DB_FALL = 8'h08;
   localparam logic [7:0] OFS_DB_RISE = 8'h0c;
   localparam logic [7:0] OFS_SD_CTRL = 8'h10;
   localparam logic [7:0] OFS_SD_SRC = 8'h14;
   localparam logic [7:0] OFS_STEER = 8'h18;
   localparam logic [7:0] OFS_PIN_EN = 8'h1c;
   localparam logic [7:0] OFS_CLK_SEL = 8'h20;
   localparam logic [7:0] OFS_IN_SEL = 8'h24;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;

   // ----------------------------------------------------------------------
   // Field positions, masks and reset values
   // ----------------------------------------------------------------------
   localparam int GEN_EN_BIT = 7;
   localparam int GEN_LOAD_BIT = 6;
   localparam int POL_IN_BIT = 5;
   localparam int SD_STAT_BIT = 7;
   localparam int SD_REN_BIT = 6;
   localparam logic [7:0] SRC_IMPL_MASK = 8'h77;
   localparam logic [7:0] SRC_ONES_MASK = 8'h88;
   localparam logic [7:0] RST_SD_CTRL = 8'h14;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam int IRQ_ENTER_BIT = 0;
   localparam int IRQ_RESUME_BIT = 1;

   // ----------------------------------------------------------------------
   // Mode, override and source codes
   // ----------------------------------------------------------------------
   localparam logic [2:0] MODE_STEER = 3'h0;
   localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
   localparam logic [2:0] MODE_PUSH_PULL = 3'h5;
   localparam logic [1:0] OVR_HIGH = 2'h3;
   localparam logic [1:0] OVR_LOW = 2'h2;
   localparam logic [1:0] OVR_FLOAT = 2'h1;
   localparam logic [1:0] OVR_INACTIVE = 2'h0;
   localparam logic [2:0] IS_PIN = 3'h0;
   localparam logic [2:0] IS_CMP1 = 3'h1;
   localparam logic [2:0] IS_CMP2 = 3'h2;
   localparam logic [2:0] IS_CCP1 = 3'h3;
   localparam logic [2:0] IS_CCP2 = 3'h4;

   // Shutdown drive of one pin: {float, level} from its pair override code.
   function automatic logic [1:0] wgss_override(input logic [1:0] code,
                                                input logic pol);
      unique case (code)
         OVR_HIGH: wgss_override = 2'h1;
         OVR_LOW: wgss_override = 2'h0;
         OVR_FLOAT: wgss_override = 2'h2;
         default: wgss_override = {1'b0, pol};
      endcase
   endfunction : wgss_override

endpackage : wgss_pkg

// ===== wgss_shutdown.sv
`timescale 1ns/100ps
module wgss_shutdown (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic src_hit,
   input wire logic sw_write,
   input wire logic sw_value,
   input wire logic restart_en,
   input wire logic data_rise,
   output logic shutdown,
   output logic hold,
   output logic enter_pulse,
   output logic resume_pulse
);
   import wgss_pkg::*;

   // ----------------------------------------------------------------------
   // Shutdown status and output hold
   // ----------------------------------------------------------------------

   // A live source always wins over software and over auto-restart.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shutdown <= 1'b0;
      end else if (src_hit) begin
         shutdown <= 1'b1;
      end else if (sw_write) begin
         shutdown <= sw_value;
      end else if (restart_en) begin
         shutdown <= 1'b0;
      end
   end

   // Overrides stay until the first input rise after the status clears.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold <= 1'b0;
      end else if (shutdown) begin
         hold <= 1'b1;
      end else if (data_rise) begin
         hold <= 1'b0;
      end
   end

   // One-cycle events for the interrupt status.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enter_pulse <= 1'b0;
         resume_pulse <= 1'b0;
      end else begin
         enter_pulse <= src_hit & ~shutdown;
         resume_pulse <= hold & ~shutdown & data_rise;
      end
   end

endmodule : wgss_shutdown

// ===== wgss_steer.sv
`timescale 1ns/100ps
module wgss_steer (
   input wire logic [2:0] mode,
   input wire logic gen_en,
   input wire logic hold,
   input wire logic [1:0] ovr_bd,
   input wire logic [1:0] ovr_ac,
   input wire logic [3:0] invert,
   input wire logic [3:0] steer_select,
   input wire logic [3:0] steer_level,
   input wire logic [3:0] pin_drive,
   input wire logic data,
   output logic [3:0] next_level,
   output logic [3:0] next_drive
);
   import wgss_pkg::*;

   // ----------------------------------------------------------------------
   // Per-output level and drive selection
   // ----------------------------------------------------------------------

   // Pins 0 and 2 follow the A/C override, pins 1 and 3 the B/D one.
   always_comb begin
      logic [1:0] ovr;
      ovr = 2'h0;
      for (int i = 0; i < 4; i++) begin
         ovr = wgss_override((i % 2 == 0) ? ovr_ac : ovr_bd, invert[i]);
         if (hold) begin
            next_level[i] = ovr[0];
            next_drive[i] = pin_drive[i] & ~ovr[1];
         end else if (mode[2:1] == MODE_STEER[2:1]) begin
            next_level[i] = steer_select[i] ? (data ^ invert[i])
                                            : steer_level[i];
            next_drive[i] = pin_drive[i] & gen_en;
         end else begin
            next_level[i] = data ^ invert[i];
            next_drive[i] = pin_drive[i] & gen_en;
         end
      end
   end

endmodule : wgss_steer

// ===== wgss_top.sv
`timescale 1ns/100ps
module wgss_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic wave_input_pin,
   input wire logic comparator_one_synced,
   input wire logic comparator_two_synced,
   input wire logic capture_compare_one_output,
   input wire logic capture_compare_two_output,
   input wire logic timer_a_postscale,
   input wire logic timer_b_postscale,
   input wire logic timer_c_postscale,
   output logic fast_internal_oscillator_pick,
   output logic [2:0] mode_out,
   output logic [5:0] rise_deadband,
   output logic [5:0] fall_deadband,
   output logic generated_data_waveform,
   output logic [3:0] out_level,
   output logic [3:0] out_drive,
   output logic irq
);
   import wgss_pkg::*;

   // ----------------------------------------------------------------------
   // Registers and internal signals
   // ----------------------------------------------------------------------
   logic gen_en;
   logic load_req;
   logic [2:0] mode;
   logic [3:0] invert;
   logic [5:0] db_fall;
   logic [5:0] db_rise;
   logic restart_en;
   logic [1:0] pair_bd_override_level;
   logic [1:0] pair_ac_override_level;
   logic [7:0] src_en;
   logic [3:0] steer_level;
   logic [3:0] steer_select;
   logic [3:0] steer_applied;
   logic [3:0] pin_drive;
   logic clk_pick;
   logic [2:0] wave_source_pick;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic wr_pend;
   logic rd_pend;
   logic [7:0] dp_addr;
   logic shutdown;
   logic hold;
   logic enter_pulse;
   logic resume_pulse;
   logic data;
   logic data_q;
   logic data_rise;
   logic data_evt;
   logic src_hit;
   logic [7:0] src_live;
   logic [3:0] next_level;
   logic [3:0] next_drive;
   logic [7:0] wd;

   // Picks the waveform source; reserved codes give a quiet low level.
   function automatic logic wgss_pick(input logic [2:0] code,
                                      input logic [4:0] srcs);
      unique case (code)
         IS_PIN: wgss_pick = srcs[0];
         IS_CMP1: wgss_pick = srcs[1];
         IS_CMP2: wgss_pick = srcs[2];
         IS_CCP1: wgss_pick = srcs[3];
         IS_CCP2: wgss_pick = srcs[4];
         default: wgss_pick = 1'b0;
      endcase
   endfunction : wgss_pick

   // Write decode for the pending data phase.
   function automatic logic wgss_hit(input logic pend,
                                     input logic [7:0] a,
                                     input logic [7:0] ofs);
      wgss_hit = pend && (a == ofs);
   endfunction : wgss_hit

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------

   // Zero wait states and always OKAY.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wd = hwdata[7:0];

   // Captures the address phase of each accepted transfer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 8'h00;
      end else if (hready) begin
         wr_pend <= hsel & htrans[1] & hwrite;
         rd_pend <= hsel & htrans[1] & ~hwrite;
         dp_addr <= {haddr[7:2], 2'b00};
      end
   end

   // Read data follows the registered address; unmapped words read zero.
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_pend) begin
         unique case (dp_addr)
            OFS_GEN_CTRL: hrdata[7:0] = {gen_en, load_req, 3'h0, mode};
            OFS_POLARITY: hrdata[7:0] = {2'h0, data, 1'b0, invert};
            OFS_DB_FALL: hrdata[7:0] = {2'h0, db_fall};
            OFS_DB_RISE: hrdata[7:0] = {2'h0, db_rise};
            OFS_SD_CTRL: hrdata[7:0] = {shutdown, restart_en,
                                        pair_bd_override_level,
                                        pair_ac_override_level, 2'h0};
            OFS_SD_SRC: hrdata[7:0] = src_en | SRC_ONES_MASK;
            OFS_STEER: hrdata[7:0] = {steer_level, steer_select};
            OFS_PIN_EN: hrdata[7:0] = {4'h0, pin_drive};
            OFS_CLK_SEL: hrdata[7:0] = {7'h00, clk_pick};
            OFS_IN_SEL: hrdata[7:0] = {5'h00, wave_source_pick};
            OFS_IRQ_STAT: hrdata[7:0] = {6'h00, irq_stat};
            OFS_IRQ_MASK: hrdata[7:0] = {6'h00, irq_mask};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------

   // Generator control; the load request is cleared at a waveform edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gen_en <= 1'b0;
         load_req <= 1'b0;
         mode <= MODE_STEER;
      end else if (wgss_hit(wr_pend, dp_addr, OFS_GEN_CTRL)) begin
         gen_en <= wd[GEN_EN_BIT];
         load_req <= wd[GEN_LOAD_BIT] & gen_en;
         mode <= wd[2:0];
      end else if (data_evt) begin
         load_req <= 1'b0;
      end
   end

   // Polarity and dead-band counts for the mode engine.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         invert <= 4'h0;
         db_fall <= 6'h00;
         db_rise <= 6'h00;
      end else begin
         if (wgss_hit(wr_pend, dp_addr, OFS_POLARITY)) begin
            invert <= wd[3:0];
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_DB_FALL)) begin
            db_fall <= wd[5:0];
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_DB_RISE)) begin
            db_rise <= wd[5:0];
         end
      end
   end

   // Shutdown control; the status bit itself lives in the shutdown unit.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         restart_en <= RST_SD_CTRL[SD_REN_BIT];
         pair_bd_override_level <= RST_SD_CTRL[5:4];
         pair_ac_override_level <= RST_SD_CTRL[3:2];
         src_en <= RST_ZERO;
      end else begin
         if (wgss_hit(wr_pend, dp_addr, OFS_SD_CTRL)) begin
            restart_en <= wd[SD_REN_BIT];
            pair_bd_override_level <= wd[5:4];
            pair_ac_override_level <= wd[3:2];
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_SD_SRC)) begin
            src_en <= wd & SRC_IMPL_MASK;
         end
      end
   end

   // Steering, pin enables, clock and input selection all reset to zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         steer_level <= 4'h0;
         steer_select <= 4'h0;
         pin_drive <= 4'h0;
         clk_pick <= 1'b0;
         wave_source_pick <= IS_PIN;
      end else begin
         if (wgss_hit(wr_pend, dp_addr, OFS_STEER)) begin
            steer_level <= wd[7:4];
            steer_select <= wd[3:0];
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_PIN_EN)) begin
            pin_drive <= wd[3:0];
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_CLK_SEL)) begin
            clk_pick <= wd[0];
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_IN_SEL)) begin
            wave_source_pick <= wd[2:0];
         end
      end
   end

   // In synchronous steering the enables wait for a waveform edge.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         steer_applied <= 4'h0;
      end else if (mode != MODE_SYNC_STEER || data_evt) begin
         steer_applied <= steer_select;
      end
   end

   // ----------------------------------------------------------------------
   // Waveform source and shutdown sources
   // ----------------------------------------------------------------------
   assign data = wgss_pick(wave_source_pick,
                           {capture_compare_two_output,
                            capture_compare_one_output,
                            comparator_two_synced, comparator_one_synced,
                            wave_input_pin});
   assign data_rise = data & ~data_q;
   assign data_evt = data ^ data_q;
   assign src_live = {1'b0, timer_c_postscale, timer_b_postscale,
                      timer_a_postscale, 1'b0, comparator_two_synced,
                      comparator_one_synced, wave_input_pin};
   assign src_hit = |(src_live & src_en);

   // Previous waveform level for edge detection.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= 1'b0;
      end else begin
         data_q <= data;
      end
   end

   wgss_shutdown u_shutdown (
      .hclk(hclk),
      .hresetn(hresetn),
      .src_hit(src_hit),
      .sw_write(wgss_hit(wr_pend, dp_addr, OFS_SD_CTRL)),
      .sw_value(wd[SD_STAT_BIT]),
      .restart_en(restart_en),
      .data_rise(data_rise),
      .shutdown(shutdown),
      .hold(hold),
      .enter_pulse(enter_pulse),
      .resume_pulse(resume_pulse)
   );

   wgss_steer u_steer (
      .mode(mode),
      .gen_en(gen_en),
      .hold(hold),
      .ovr_bd(pair_bd_override_level),
      .ovr_ac(pair_ac_override_level),
      .invert(invert),
      .steer_select(steer_applied),
      .steer_level(steer_level),
      .pin_drive(pin_drive),
      .data(data),
      .next_level(next_level),
      .next_drive(next_drive)
   );

   // ----------------------------------------------------------------------
   // Outputs and interrupt
   // ----------------------------------------------------------------------

   // Pin levels and drives are registered to avoid glitches on switches.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_level <= 4'h0;
         out_drive <= 4'h0;
         generated_data_waveform <= 1'b0;
      end else begin
         out_level <= next_level;
         out_drive <= next_drive;
         generated_data_waveform <= data;
      end
   end

   // Sticky events, cleared by writing one; a new event wins the clear.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         if (wgss_hit(wr_pend, dp_addr, OFS_IRQ_STAT)) begin
            irq_stat <= (irq_stat & ~wd[1:0]) |
                        {resume_pulse, enter_pulse};
         end else begin
            irq_stat <= irq_stat | {resume_pulse, enter_pulse};
         end
         if (wgss_hit(wr_pend, dp_addr, OFS_IRQ_MASK)) begin
            irq_mask <= wd[1:0];
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);
   assign fast_internal_oscillator_pick = clk_pick;
   assign mode_out = mode;
   assign rise_deadband = db_rise;
   assign fall_deadband = db_fall;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_src_ones;
      @(posedge hclk) disable iff (!hresetn)
      (rd_pend && dp_addr == OFS_SD_SRC) |-> (hrdata[7:0] & 8'h88) == 8'h88;
   endproperty
   a_src_ones: assert property (p_src_ones)
      else $error("Source register reserved bits not read as one.");

   property p_hit_sets;
      @(posedge hclk) disable iff (!hresetn)
      src_hit |=> shutdown ##1 hold;
   endproperty
   a_hit_sets: assert property (p_hit_sets)
      else $error("Enabled source did not enter shutdown.");

   property p_restart;
      @(posedge hclk) disable iff (!hresetn)
      (shutdown && restart_en && !src_hit &&
       !wgss_hit(wr_pend, dp_addr, OFS_SD_CTRL)) |=> !shutdown;
   endproperty
   a_restart: assert property (p_restart)
      else $error("Auto-restart did not clear shutdown.");

   property p_hold_keeps;
      @(posedge hclk) disable iff (!hresetn)
      (hold && !shutdown && !data_rise) |=> hold;
   endproperty
   a_hold_keeps: assert property (p_hold_keeps)
      else $error("Overrides released without a rising edge.");

   property p_steer_data;
      @(posedge hclk) disable iff (!hresetn)
      (!hold && mode == MODE_STEER && steer_applied[0])
         |=> out_level[0] == ($past(data) ^ $past(invert[0]));
   endproperty
   a_steer_data: assert property (p_steer_data)
      else $error("Steered output A does not follow the waveform.");

   property p_steer_level;
      @(posedge hclk) disable iff (!hresetn)
      (!hold && mode[2:1] == 2'h0 && !steer_applied[1])
         |=> out_level[1] == $past(steer_level[1]);
   endproperty
   a_steer_level: assert property (p_steer_level)
      else $error("Output B does not carry its steering data.");

   property p_sync_buffer;
      @(posedge hclk) disable iff (!hresetn)
      (mode == MODE_SYNC_STEER && !data_evt) |=> $stable(steer_applied);
   endproperty
   a_sync_buffer: assert property (p_sync_buffer)
      else $error("Synchronous steering applied without an edge.");

   property p_pin_off;
      @(posedge hclk) disable iff (!hresetn)
      !pin_drive[3] |=> !out_drive[3];
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("Disabled pin D is still driven.");

   property p_float;
      @(posedge hclk) disable iff (!hresetn)
      (hold && pair_ac_override_level == OVR_FLOAT) |=> !out_drive[2];
   endproperty
   a_float: assert property (p_float)
      else $error("Floating override still drives pin C.");

endmodule : wgss_top

// ===== wgss_switch_model.sv
`timescale 1ns/100ps
// Four external power switches; an undriven pin wanders each cycle.
module wgss_switch_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] out_level,
   input wire logic [3:0] out_drive,
   output logic [3:0] pin
);
   // A released pin flips so a stale level never passes for drive.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin <= 4'h0;
      end else begin
         pin <= (out_level & out_drive) | (~pin & ~out_drive);
      end
   end
endmodule : wgss_switch_model

// ===== test_waveform_generator_shutdown_steering.sv
`timescale 1ns/100ps
module test_waveform_generator_shutdown_steering;
   import wgss_pkg::*;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] w;
      logic [7:0] r;
   } wgss_row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] ins = 8'h00;
   logic hready, irq, fpick, gdw;
   logic hresp;
   logic [2:0] mo;
   logic [5:0] dbr, dbf;
   logic [31:0] hrdata, r;
   logic [3:0] lvl, drv, sw_pin, e;
   int err_count = 0;
   int checks = 0;
   int src [5] = '{0, 1, 2, 3, 7};
   wgss_row_t rows [12] = '{'{OFS_SD_SRC, 8'hff, 8'hff},
      '{OFS_SD_SRC, 8'h00, 8'h88}, '{OFS_PIN_EN, 8'hff, 8'h0f},
      '{OFS_CLK_SEL, 8'hfe, 8'h00}, '{OFS_GEN_CTRL, 8'h3d, 8'h05},
      '{OFS_POLARITY, 8'hff, 8'h0f}, '{OFS_DB_FALL, 8'hff, 8'h3f},
      '{OFS_DB_RISE, 8'hea, 8'h2a}, '{OFS_IRQ_MASK, 8'hff, 8'h03},
      '{OFS_SD_CTRL, 8'h6c, 8'h6c}, '{OFS_IN_SEL, 8'h04, 8'h04},
      '{8'h3c, 8'h5a, 8'h00}};

   // Clock of 5 ns.
   always #2.5 hclk = ~hclk;

   wgss_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .wave_input_pin(ins[0]),
      .comparator_one_synced(ins[1]), .comparator_two_synced(ins[2]),
      .capture_compare_one_output(ins[3]),
      .capture_compare_two_output(ins[7]), .timer_a_postscale(ins[4]),
      .timer_b_postscale(ins[5]), .timer_c_postscale(ins[6]),
      .fast_internal_oscillator_pick(fpick), .mode_out(mo),
      .rise_deadband(dbr), .fall_deadband(dbf), .generated_data_waveform(gdw),
      .out_level(lvl), .out_drive(drv), .irq(irq));

   wgss_switch_model sw (.hclk(hclk), .hresetn(hresetn),
      .out_level(lvl), .out_drive(drv), .pin(sw_pin));

   // ------------
   // Bus and checks
   // ------------
   task automatic summarize;
      if (err_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic chk_reg(string n, logic [31:0] x, logic [31:0] g);
      checks++;
      if (g !== x) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask : chk_reg

   task automatic chk_pin(string n, logic [3:0] x, logic [3:0] g);
      chk_reg(n, {28'h0, x}, {28'h0, g});
   endtask : chk_pin

   task automatic cyc(int n);
      repeat (n) @(posedge hclk);
   endtask : cyc

   // Waits a bounded time for hready at a rising edge.
   task automatic bus_wait;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            err_count++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask : bus_wait

   task automatic bus(logic wr, logic [7:0] a, logic [7:0] wd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      bus_wait();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      bus_wait();
      r = hrdata;
   endtask : bus

   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdc(string n, logic [7:0] a, logic [7:0] x);
      bus(1'b0, a, 8'h00);
      chk_reg(n, {24'h0, x}, r);
   endtask : rdc

   // ------------
   // Main sequence
   // ------------
   initial begin
      cyc(16);
      hresetn <= 1'b1;
      cyc(1);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rdc("register", rows[i].a, rows[i].r);
      end
      chk_pin("mode out", 4'h5, {1'b0, mo});
      chk_reg("dead bands", {20'h0, 12'hfea}, {20'h0, dbf, dbr});
      chk_pin("response", 4'h0, {3'h0, hresp});
      wr(OFS_CLK_SEL, 8'h01);
      cyc(2);
      chk_pin("clock pick", 4'h1, {3'h0, fpick});
      for (int k = 0; k < 5; k++) begin
         wr(OFS_IN_SEL, 8'(k));
         ins <= 8'h01 << src[k];
         cyc(3);
         chk_pin("data", 4'h1, {3'h0, gdw});
         ins <= ~(8'h01 << src[k]);
         cyc(3);
         chk_pin("data", 4'h0, {3'h0, gdw});
      end
      wr(OFS_IN_SEL, 8'h03);
      wr(OFS_POLARITY, 8'h05);
      wr(OFS_STEER, 8'ha3);
      for (int m = 0; m < 2; m++) begin
         wr(OFS_GEN_CTRL, m ? 8'h82 : 8'h80);
         for (int d = 0; d < 2; d++) begin
            ins <= d ? 8'h08 : 8'h00;
            cyc(4);
            e = m ? {4{d[0]}} ^ 4'h5 : {2'b10, d[0], ~d[0]};
            chk_pin("level", e, lvl);
            chk_pin("switch", e, sw_pin);
         end
      end
      wr(OFS_GEN_CTRL, 8'h80);
      wr(OFS_POLARITY, 8'h00);
      wr(OFS_STEER, 8'h50);
      wr(OFS_SD_CTRL, 8'h78);
      wr(OFS_IRQ_MASK, 8'h01);
      for (int i = 0; i < 7; i++) begin
         if (i == 3) continue;
         wr(OFS_SD_SRC, 8'h01 << i);
         ins <= 8'h77 & ~(8'h01 << i);
         cyc(6);
         chk_pin("no shutdown", 4'h5, lvl);
         ins <= 8'h77;
         cyc(6);
         chk_pin("override", 4'ha, lvl);
         chk_pin("irq", 4'h1, {3'h0, irq});
         ins <= 8'h00;
         cyc(6);
         rdc("status", OFS_SD_CTRL, 8'h78);
         chk_pin("held", 4'ha, lvl);
         ins <= 8'h08;
         cyc(6);
         chk_pin("resumed", 4'h5, lvl);
         rdc("irq status", OFS_IRQ_STAT, 8'h03);
         wr(OFS_IRQ_STAT, 8'h03);
         cyc(2);
         chk_pin("irq", 4'h0, {3'h0, irq});
      end
      wr(OFS_POLARITY, 8'h0f);
      wr(OFS_SD_CTRL, 8'h84);
      cyc(4);
      chk_pin("float drive", 4'ha, drv);
      chk_pin("inactive level", 4'ha, lvl);
      wr(OFS_SD_CTRL, 8'h00);
      wr(OFS_POLARITY, 8'h00);
      ins <= 8'h00;
      cyc(2);
      ins <= 8'h08;
      cyc(4);
      chk_pin("released", 4'h5, lvl);
      wr(OFS_STEER, 8'h00);
      wr(OFS_GEN_CTRL, 8'h81);
      wr(OFS_STEER, 8'h01);
      wr(OFS_GEN_CTRL, 8'hc1);
      cyc(4);
      chk_pin("buffered", 4'h0, lvl);
      ins <= 8'h00;
      cyc(4);
      ins <= 8'h08;
      cyc(4);
      chk_pin("applied", 4'h1, lvl);
      hresetn <= 1'b0;
      cyc(2);
      chk_pin("reset drive", 4'h0, drv);
      hresetn <= 1'b1;
      cyc(1);
      rdc("steer", OFS_STEER, 8'h00);
      rdc("pin enable", OFS_PIN_EN, 8'h00);
      rdc("clock", OFS_CLK_SEL, 8'h00);
      rdc("input", OFS_IN_SEL, 8'h00);
      rdc("source", OFS_SD_SRC, 8'h88);
      summarize();
   end
endmodule : test_waveform_generator_shutdown_steering
